/* oes_output_error_signalling.sv */
// Fault signalling on the PWM and quadrature/commutation outputs.
// Assumes one clock, synchronous inputs and an APB master with 32-bit data.
//
// What this block does
// - Reporting disabled: PWM ignores all faults
// - Reporting enabled: style select picks response
// - Style zero: tristate PWM while enabled fault
// - Style one: halved carrier, fault duty cycle
// - Highest priority active fault picks duty
// - Only individually enabled faults reach PWM
// - Oscillator, uncorrectable-memory, self-test faults are permanent
// - PLL fault holds until lock returns
// - Zero-crossing fault holds while present
// - Averaging and corrected-memory faults hold until one style-one period shows them
// - Undervoltage merges masked regulator and supply
// - Field faults hold until field recovers
// - Saturation holds while any saturation warning
// - Temperature holds until back in range
// - Turns overflow holds until control clear
// - Quadrature lines react only to oscillator, PLL
// - Quadrature fault drives all lines high pre-inversion
// - Oscillator quadrature enable in row bit 7
// - PLL quadrature enable in row bit 6
`timescale 1ns/1ps

module oes_output_error_signalling
  import oes_pkg::*;
#(
  parameter int CW     = 16,
  parameter int PERIOD = `OES_PWM_PERIOD
) (
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Fault conditions
  input  wire logic        oscillatorFrequencyFault,
  input  wire logic        memoryUncorrectableFault,
  input  wire logic        selfTestFailure,
  input  wire logic        pllUnlockedFault,
  input  wire logic        zeroCrossingIntegrityFault,
  input  wire logic        angleAveragingFault,
  input  wire logic        regulatorUndervoltage,
  input  wire logic        supplyUndervoltage,
  input  wire logic        fieldTooLow,
  input  wire logic        memoryCorrectedWarning,
  input  wire logic        signalSaturationWarning,
  input  wire logic        fieldTooHigh,
  input  wire logic        temperatureOutOfRange,
  input  wire logic        turnsCounterOverflow,
  // Normal waveforms
  input  wire logic [11:0] normalDuty,
  input  wire logic [2:0]  quadIn,
  // Outputs
  output logic             pwmOut,
  output logic             pwmOutEnable,
  output logic [2:0]       quadOut
);

  localparam int NF = `OES_NUM_FAULTS;

  // Configuration
  logic [31:0] settings;
  logic [31:0] faultEnableRow;
  logic [31:0] quadRow;

  // Fault state
  oes_faults_t pending;
  oes_faults_t enabledFaults;
  logic        uvNow;
  logic        anyEnabled;
  oes_code_t   topCode;

  // Carrier state
  oes_mode_e   mode;
  oes_code_t   runCode;
  logic [CW-1:0] count;
  logic [CW-1:0] highCount;
  logic [CW-1:0] curPeriod;
  logic          periodEnd;

  // APB decode
  logic        setupPhase;
  logic        accessPhase;
  logic        wrStrobe;
  logic        addrOk;

  function automatic logic mapped(input logic [11:0] a);
    return a == `OES_ADDR_SETTINGS || a == `OES_ADDR_FAULT_EN ||
           a == `OES_ADDR_QUAD_ROW || a == `OES_ADDR_CONTROL ||
           a == `OES_ADDR_STATUS;
  endfunction

  // Lowest index wins, index 0 is the most urgent fault
  function automatic oes_code_t top_fault(input oes_faults_t f);
    oes_code_t c;
    c = '0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = oes_code_t'(i);
      end
    end
    return c;
  endfunction

  function automatic logic [CW-1:0] fault_high(input oes_code_t c,
                                               input logic [CW-1:0] p);
    logic [31:0] num;
    logic [47:0] prod;
    num  = 32'(`OES_DUTY_BASE) + 32'(`OES_DUTY_STEP) * 32'(c);
    prod = 48'(p) * 48'(num);
    return CW'(prod / 48'(`OES_DUTY_DENOM));
  endfunction

  function automatic logic [CW-1:0] normal_high(input logic [11:0] d,
                                                input logic [CW-1:0] p);
    logic [CW+11:0] prod;
    prod = (CW+12)'(p) * (CW+12)'(d);
    return CW'(prod >> `OES_NORMAL_DUTY_W);
  endfunction

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable && pready;
  assign addrOk      = mapped(paddr);
  assign wrStrobe    = accessPhase && pwrite && addrOk;

  // Undervoltage counts only the unmasked sources
  assign uvNow = (regulatorUndervoltage &&
                  !settings[`OES_SET_REG_UV_MASK]) ||
                 (supplyUndervoltage &&
                  !settings[`OES_SET_SUP_UV_MASK]);

  assign enabledFaults = pending & faultEnableRow[NF-1:0];
  assign anyEnabled    = |enabledFaults;
  assign topCode       = top_fault(enabledFaults);

  assign curPeriod = (mode == OES_MODE_DUTY) ?
                     CW'(2 * PERIOD) : CW'(PERIOD);
  assign periodEnd = count >= curPeriod - CW'(1);

  // Configuration registers
  always_ff @(posedge clock) begin
    if (reset) begin
      settings       <= `OES_SETTINGS_RESET;
      faultEnableRow <= `OES_FAULT_EN_RESET;
      quadRow        <= `OES_QUAD_ROW_RESET;
    end else if (wrStrobe) begin
      case (paddr)
        `OES_ADDR_SETTINGS: settings <= pwdata & 32'h0000_007f;
        `OES_ADDR_FAULT_EN: faultEnableRow <= pwdata & 32'h0000_1fff;
        `OES_ADDR_QUAD_ROW: quadRow <= pwdata & 32'h0000_00c0;
        default: ;
      endcase
    end
  end

  // Fault pending bits; a set always wins over a clear
  always_ff @(posedge clock) begin
    if (reset) begin
      pending <= '0;
    end else begin
      // Sticky until reset
      if (oscillatorFrequencyFault) pending[`OES_F_OSC] <= 1'b1;
      if (memoryUncorrectableFault) pending[`OES_F_MEM_UNCORR] <= 1'b1;
      if (selfTestFailure) pending[`OES_F_SELF_TEST] <= 1'b1;
      // Level faults follow their condition
      pending[`OES_F_PLL]         <= pllUnlockedFault;
      pending[`OES_F_ZERO_CROSS]  <= zeroCrossingIntegrityFault;
      pending[`OES_F_UNDERVOLT]   <= uvNow;
      pending[`OES_F_LOW_FIELD]   <= fieldTooLow;
      pending[`OES_F_HIGH_FIELD]  <= fieldTooHigh;
      pending[`OES_F_SATURATION]  <= signalSaturationWarning;
      pending[`OES_F_TEMPERATURE] <= temperatureOutOfRange;
      // One-period faults clear after a full period shown
      if (angleAveragingFault) begin
        pending[`OES_F_AVERAGING] <= 1'b1;
      end else if (periodEnd && mode == OES_MODE_DUTY &&
                   runCode == oes_code_t'(`OES_F_AVERAGING)) begin
        pending[`OES_F_AVERAGING] <= 1'b0;
      end
      if (memoryCorrectedWarning) begin
        pending[`OES_F_MEM_CORR] <= 1'b1;
      end else if (periodEnd && mode == OES_MODE_DUTY &&
                   runCode == oes_code_t'(`OES_F_MEM_CORR)) begin
        pending[`OES_F_MEM_CORR] <= 1'b0;
      end
      // Host clear through the control register
      if (turnsCounterOverflow) begin
        pending[`OES_F_TURNS_OVF] <= 1'b1;
      end else if (wrStrobe && paddr == `OES_ADDR_CONTROL &&
                   pwdata[`OES_CTRL_TOV_CLEAR]) begin
        pending[`OES_F_TURNS_OVF] <= 1'b0;
      end
    end
  end

  // Carrier mode and duty change only at a period boundary, so a
  // host never sees a clipped pulse; tristate acts at once.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode      <= OES_MODE_NORMAL;
      runCode   <= '0;
      count     <= '0;
      highCount <= normal_high(12'h000, CW'(PERIOD));
    end else begin
      if (settings[`OES_SET_REPORT_EN] && !settings[`OES_SET_STYLE] &&
          anyEnabled) begin
        mode  <= OES_MODE_TRISTATE;
        count <= '0;
      end else if (periodEnd || mode == OES_MODE_TRISTATE) begin
        count <= '0;
        if (settings[`OES_SET_REPORT_EN] && anyEnabled) begin
          mode      <= OES_MODE_DUTY;
          runCode   <= topCode;
          highCount <= fault_high(topCode, CW'(2 * PERIOD));
        end else begin
          mode      <= OES_MODE_NORMAL;
          highCount <= normal_high(normalDuty, CW'(PERIOD));
        end
      end else begin
        count <= count + CW'(1);
      end
    end
  end

  // PWM pin
  always_ff @(posedge clock) begin
    if (reset) begin
      pwmOut       <= 1'b0;
      pwmOutEnable <= 1'b0;
    end else begin
      case (mode)
        OES_MODE_TRISTATE: begin
          pwmOut       <= 1'b0;
          pwmOutEnable <= 1'b0;
        end
        OES_MODE_NORMAL,
        OES_MODE_DUTY: begin
          pwmOut       <= count < highCount;
          pwmOutEnable <= 1'b1;
        end
        default: begin
          pwmOut       <= 1'b0;
          pwmOutEnable <= 1'b1;
        end
      endcase
    end
  end

  // Quadrature lines: only the oscillator and PLL faults break the stream
  always_ff @(posedge clock) begin
    if (reset) begin
      quadOut <= 3'h0;
    end else if ((quadRow[`OES_QUAD_OSC_EN] &&
                  pending[`OES_F_OSC]) ||
                 (quadRow[`OES_QUAD_PLL_EN] &&
                  pllUnlockedFault)) begin
      quadOut <= 3'h7 ^ settings[`OES_SET_INV_LSB +: 3];
    end else begin
      quadOut <= quadIn ^ settings[`OES_SET_INV_LSB +: 3];
    end
  end

  // APB answer: zero wait states, read data latched in setup
  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !addrOk;
      if (setupPhase && !pwrite) begin
        case (paddr)
          `OES_ADDR_SETTINGS: prdata <= settings;
          `OES_ADDR_FAULT_EN: prdata <= faultEnableRow;
          `OES_ADDR_QUAD_ROW: prdata <= quadRow;
          `OES_ADDR_STATUS: begin
            prdata <= 32'h0000_0000;
            prdata[NF-1:0] <= pending;
            prdata[`OES_STAT_CODE_LSB +: 4] <= runCode;
            prdata[`OES_STAT_ERR_MODE] <= mode == OES_MODE_DUTY;
            prdata[`OES_STAT_TRISTATE] <= mode == OES_MODE_TRISTATE;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* oes_consts.svh */
// Constants for the output fault signalling block.
// Assumes inclusion by bare name from the package.
`ifndef OES_CONSTS_SVH
`define OES_CONSTS_SVH

// Register byte addresses on the APB
`define OES_ADDR_SETTINGS   12'h000
`define OES_ADDR_FAULT_EN   12'h004
`define OES_ADDR_QUAD_ROW   12'h008
`define OES_ADDR_CONTROL    12'h00c
`define OES_ADDR_STATUS     12'h010

// Settings fields
`define OES_SET_REPORT_EN   0
`define OES_SET_STYLE       1
`define OES_SET_REG_UV_MASK 2
`define OES_SET_SUP_UV_MASK 3
`define OES_SET_INV_LSB     4
`define OES_SETTINGS_RESET  32'h0000_0000
`define OES_FAULT_EN_RESET  32'h0000_0000

// Quadrature row fields
`define OES_QUAD_OSC_EN     7
`define OES_QUAD_PLL_EN     6
`define OES_QUAD_ROW_RESET  32'h0000_0000

// Control fields
`define OES_CTRL_TOV_CLEAR  0

// Status fields
`define OES_STAT_CODE_LSB   16
`define OES_STAT_ERR_MODE   20
`define OES_STAT_TRISTATE   21

// Fault indices, highest priority first
`define OES_NUM_FAULTS      13
`define OES_F_OSC           0
`define OES_F_MEM_UNCORR    1
`define OES_F_SELF_TEST     2
`define OES_F_PLL           3
`define OES_F_ZERO_CROSS    4
`define OES_F_AVERAGING     5
`define OES_F_UNDERVOLT     6
`define OES_F_LOW_FIELD     7
`define OES_F_MEM_CORR      8
`define OES_F_SATURATION    9
`define OES_F_HIGH_FIELD    10
`define OES_F_TEMPERATURE   11
`define OES_F_TURNS_OVF     12

// Fault duty cycles in units of 1/1600 of the period
`define OES_DUTY_DENOM      1600
`define OES_DUTY_BASE       80
`define OES_DUTY_STEP       90

// Normal duty input is a fraction of 2**12
`define OES_NORMAL_DUTY_W   12

// Carrier period in clock cycles
`define OES_PWM_PERIOD      1000

`endif

/* oes_pkg.sv */
// Types shared by the output fault signalling block.
// Assumes oes_consts.svh sits in the include path.
`include "oes_consts.svh"

package oes_pkg;

  typedef enum logic [1:0] {
    OES_MODE_NORMAL,
    OES_MODE_TRISTATE,
    OES_MODE_DUTY
  } oes_mode_e;

  typedef logic [`OES_NUM_FAULTS-1:0] oes_faults_t;

  typedef logic [3:0] oes_code_t;

endpackage

/* oes_output_error_signalling_monitor.sv */
// Checker for the output fault signalling block.
// Assumes bind to the top module; tracks APB writes to know the setup.
`timescale 1ns/1ps
module oes_output_error_signalling_monitor (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        oscillatorFrequencyFault,
  input wire logic        pllUnlockedFault,
  input wire logic        temperatureOutOfRange,
  input wire logic [2:0]  quadIn,
  input wire logic        pwmOutEnable,
  input wire logic [2:0]  quadOut
);
  logic [1:0]  setCopy;
  logic [2:0]  invCopy;
  logic [12:0] fenCopy;
  logic [1:0]  quadCopy;
  logic        oscSeen;
  logic        wr;
  assign wr = psel && penable && pready && pwrite;
  // Shadow of the setup, updated at the same edge as the design
  always_ff @(posedge clock) begin
    if (reset) begin
      setCopy  <= 2'h0;
      invCopy  <= 3'h0;
      fenCopy  <= 13'h0;
      quadCopy <= 2'h0;
      oscSeen  <= 1'b0;
    end else begin
      if (wr && paddr == 12'h000) setCopy <= pwdata[1:0];
      if (wr && paddr == 12'h000) invCopy <= pwdata[6:4];
      if (wr && paddr == 12'h004) fenCopy <= pwdata[12:0];
      if (wr && paddr == 12'h008) quadCopy <= pwdata[7:6];
      if (oscillatorFrequencyFault) oscSeen <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no access cycle after setup");
  no_report_a: assert property (!setCopy[0] |=> ##1 pwmOutEnable)
    else $error("pwm released with reporting off");
  fen_zero_a: assert property (fenCopy == 13'h0 |=> ##1 pwmOutEnable)
    else $error("pwm released with no fault enabled");
  temp_tri_a: assert property ((setCopy == 2'b01 && fenCopy[11]
    && temperatureOutOfRange) [*3] |=> !pwmOutEnable)
    else $error("pwm not tristated on enabled fault");
  pll_tri_a: assert property ((setCopy == 2'b01 && fenCopy[3]
    && pllUnlockedFault) [*3] |=> !pwmOutEnable)
    else $error("pwm not tristated on pll fault");
  osc_quad_a: assert property (quadCopy[1] && oscSeen
    |=> quadOut == (3'h7 ^ $past(invCopy)))
    else $error("quad lines not high on oscillator fault");
  pll_quad_a: assert property (quadCopy[0] && pllUnlockedFault
    |=> quadOut == (3'h7 ^ $past(invCopy)))
    else $error("quad lines not high on pll fault");
  quad_pass_a: assert property (!(quadCopy[1] && oscSeen)
    && !(quadCopy[0] && pllUnlockedFault)
    |=> quadOut == ($past(quadIn) ^ $past(invCopy)))
    else $error("quad lines disturbed without enabled fault");
endmodule

bind oes_output_error_signalling oes_output_error_signalling_monitor i_mon (
  .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .oscillatorFrequencyFault, .pllUnlockedFault, .temperatureOutOfRange,
  .quadIn, .pwmOutEnable, .quadOut);

/* oes_host_decoder.sv */
// Host side model that times the PWM line.
// Assumes the host samples the line on the block's clock.
`timescale 1ns/1ps
module oes_host_decoder (
  input  wire logic        clock,
  input  wire logic        pwmOut,
  input  wire logic        pwmOutEnable,
  output logic [15:0]      highTime,
  output logic [15:0]      periodTime
);
  logic [15:0] hiCnt = 16'h0;
  logic [15:0] perCnt = 16'h0;
  logic        lastLevel = 1'b0;
  // Rise to rise; a floating line reads low, as with a pull-down
  always @(posedge clock) begin
    lastLevel <= pwmOut && pwmOutEnable;
    if (pwmOut && pwmOutEnable && !lastLevel) begin
      highTime   <= hiCnt;
      periodTime <= perCnt;
      hiCnt      <= 16'h1;
      perCnt     <= 16'h1;
    end else begin
      hiCnt  <= hiCnt + ((pwmOut && pwmOutEnable) ? 16'h1 : 16'h0);
      perCnt <= perCnt + 16'h1;
    end
  end
endmodule

/* tb_top.sv */
// Testbench for the output fault signalling block.
// Assumes a short carrier (PERIOD 40) and the host decoder model.
`timescale 1ns/1ps
module tb_top;
  logic        clock, reset, psel, penable, pwrite, err;
  logic        pready, pslverr, pwmOut, pwmOutEnable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [13:0] flt;
  logic [2:0]  quadIn, quadOut;
  logic [15:0] highTime, periodTime;
  int          fail_count, samples_checked;

  oes_output_error_signalling #(.PERIOD(40)) i_oes_output_error_signalling (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .oscillatorFrequencyFault(flt[0]), .memoryUncorrectableFault(flt[1]),
    .selfTestFailure(flt[2]), .pllUnlockedFault(flt[3]),
    .zeroCrossingIntegrityFault(flt[4]), .angleAveragingFault(flt[5]),
    .regulatorUndervoltage(flt[6]), .supplyUndervoltage(flt[7]),
    .fieldTooLow(flt[8]), .memoryCorrectedWarning(flt[9]),
    .signalSaturationWarning(flt[10]), .fieldTooHigh(flt[11]),
    .temperatureOutOfRange(flt[12]), .turnsCounterOverflow(flt[13]),
    .normalDuty(12'h800), .quadIn(quadIn), .pwmOut(pwmOut),
    .pwmOutEnable(pwmOutEnable), .quadOut(quadOut));
  oes_host_decoder i_oes_host_decoder (.clock(clock), .pwmOut(pwmOut),
    .pwmOutEnable(pwmOutEnable), .highTime(highTime),
    .periodTime(periodTime));

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask
  // Holds the request until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Look mid-cycle, where the registered answer has settled
    @(negedge clock);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    if (n == 50) fail_count++;
    rdq = prdata;
    err = pslverr;
    @(posedge clock);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Several periods pass so the decoder holds a whole clean one
  task automatic pwm(input int hi, input int per);
    repeat (300) @(posedge clock);
    @(negedge clock);
    chk("pwm high time", hi, {16'h0, highTime});
    chk("pwm period", per, {16'h0, periodTime});
    @(posedge clock);
  endtask
  task automatic en(input logic [13:0] f, input logic ex);
    flt <= f;
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk("pwm enable", {31'h0, ex}, {31'h0, pwmOutEnable});
    @(posedge clock);
  endtask
  task automatic quad(input logic [13:0] f, input logic [2:0] ex);
    flt <= f;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk("quad lines", {29'h0, ex}, {29'h0, quadOut});
    @(posedge clock);
  endtask

  task automatic t_regs;
    apb(12'h000, 1'b0, 32'h0);
    chk("settings reset", 32'h0, rdq);
    apb(12'h004, 1'b1, 32'hffff_ffff);
    apb(12'h004, 1'b0, 32'h0);
    chk("fault enables", 32'h1fff, rdq);
    apb(12'h0ff, 1'b0, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    en(14'h1000, 1'b1);
    pwm(20, 40);
    $display("register and reporting-off test done");
  endtask
  task automatic t_tri;
    apb(12'h004, 1'b1, 32'h0808);
    apb(12'h000, 1'b1, 32'h1);
    en(14'h0800, 1'b1);
    en(14'h1000, 1'b0);
    en(14'h0000, 1'b1);
    en(14'h0008, 1'b0);
    en(14'h0000, 1'b1);
    $display("tristate test done");
  endtask
  task automatic t_duty;
    apb(12'h004, 1'b1, 32'h1fff);
    apb(12'h000, 1'b1, 32'h3);
    flt <= 14'h1008;
    pwm(17, 80);
    flt <= 14'h1000;
    pwm(53, 80);
    flt <= 14'h0040;
    pwm(31, 80);
    apb(12'h000, 1'b1, 32'h7);
    pwm(20, 40);
    quad(14'h2000, 3'b010);
    flt <= 14'h0;
    pwm(58, 80);
    apb(12'h00c, 1'b1, 32'h1);
    pwm(20, 40);
    quad(14'h0020, 3'b010);
    flt <= 14'h0;
    apb(12'h010, 1'b0, 32'h0);
    chk("averaging pending", 32'h1, {31'h0, rdq[5]});
    pwm(20, 40);
    apb(12'h010, 1'b0, 32'h0);
    chk("averaging pending", 32'h0, {31'h0, rdq[5]});
    $display("duty cycle test done");
  endtask
  task automatic t_quad;
    apb(12'h000, 1'b1, 32'h13);
    apb(12'h008, 1'b1, 32'h0);
    quad(14'h0008, 3'b011);
    apb(12'h008, 1'b1, 32'h40);
    quad(14'h0008, 3'b110);
    quad(14'h1000, 3'b011);
    apb(12'h008, 1'b1, 32'hc0);
    quad(14'h0001, 3'b110);
    quad(14'h0000, 3'b110);
    pwm(4, 80);
    $display("quadrature test done");
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results;
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, flt} = {4'h8, 58'h0};
    quadIn = 3'b010;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs;
    t_tri;
    t_duty;
    t_quad;
    results;
  end
endmodule
